// ===== design/dtcu_pkg.sv
/*
 * Constants for the dual timer/counter unit: register indices, field
 * positions, reset values, mode codes and the peripheral cycle length.
 * Assumes a single 20 MHz timer clock and an APB slave with 32-bit data.
 */
package dtcu_pkg;
    // Register indices; the APB byte address is four times the index
    localparam logic [7:0] IDX_TIMER_CONTROL = 8'h88;
    localparam logic [7:0] IDX_TIMER_MODE_SELECT = 8'h89;
    localparam logic [7:0] IDX_TIMER_A_LOW_BYTE = 8'h8a;
    localparam logic [7:0] IDX_TIMER_B_LOW_BYTE = 8'h8b;
    localparam logic [7:0] IDX_TIMER_A_HIGH_BYTE = 8'h8c;
    localparam logic [7:0] IDX_TIMER_B_HIGH_BYTE = 8'h8d;
    localparam logic [7:0] IDX_IRQ_ENABLE_REG_ZERO = 8'ha8;
    localparam int ADDR_W = 12;

    // Control register fields; timer b sits two bits above timer a
    localparam int EXT_IRQ_A_EDGE_SELECT = 0;
    localparam int EXT_IRQ_A_FLAG = 1;
    localparam int TIMER_A_RUN = 4;
    localparam int TIMER_A_OVERFLOW_FLAG = 5;
    localparam int TIMER_B_STRIDE = 2;
    localparam int TIMER_B_RUN = 6;
    localparam int TIMER_B_OVERFLOW_FLAG = 7;

    // Mode register fields; timer b sits one nibble above timer a
    localparam int MODE_LO = 0;
    localparam int SOURCE_SELECT = 2;
    localparam int PIN_GATING = 3;
    localparam int MODE_NIBBLE = 4;

    // Interrupt enable register fields
    localparam int EXT_IRQ_A_ENABLE = 0;
    localparam int TIMER_A_IRQ_ENABLE = 1;
    localparam int EXT_IRQ_B_ENABLE = 2;
    localparam int TIMER_B_IRQ_ENABLE = 3;
    localparam int GLOBAL_IRQ_ENABLE = 7;

    // Mode codes
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // Reset values
    localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] RST_TIMER_MODE_SELECT = 8'h00;
    localparam logic [7:0] RST_COUNT_BYTE = 8'h00;
    localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;

    // One peripheral cycle is this many timer clock periods
    localparam int PER_CYCLE_CLOCKS = 6;
    localparam logic [2:0] PRE_LAST = 3'(PER_CYCLE_CLOCKS - 1);
endpackage

// ===== design/dtcu_top.sv
/*
 * Dual timer/counter unit with its control, mode and count byte registers,
 * external interrupt flags and interrupt enable register behind APB.
 * Assumes clk is the timer clock, reset is synchronous, and the count and
 * interrupt pins are asynchronous to clk. Vector acknowledges are one-cycle
 * pulses from the interrupt controller.
 */
`timescale 1ns/10ps
module dtcu_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dtcu_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_a_count_pin,
    input wire logic timer_b_count_pin,
    input wire logic ext_irq_a_pin,
    input wire logic ext_irq_b_pin,
    input wire logic timer_a_vector_ack,
    input wire logic timer_b_vector_ack,
    input wire logic ext_irq_a_vector_ack,
    input wire logic ext_irq_b_vector_ack,
    output logic timer_a_irq,
    output logic timer_b_irq,
    output logic ext_irq_a_irq,
    output logic ext_irq_b_irq
);
    typedef struct packed {
        logic [2:0] pre;
        logic [7:0] timer_control;
        logic [7:0] timer_mode_select;
        logic [7:0] ien;
        logic [1:0][7:0] tl;
        logic [1:0][7:0] th;
        logic [1:0] csync1;
        logic [1:0] csync2;
        logic [1:0] csamp;
        logic [1:0] isync1;
        logic [1:0] isync2;
        logic [1:0] iprev;
        logic [7:0] rdata;
        logic err;
    } dtcu_state_s;

    dtcu_state_s st_r;
    dtcu_state_s st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic [7:0] idx;
    logic addr_ok;
    logic wr;
    logic [1:0] wr_tl;
    logic [1:0] wr_th;
    logic wr_timer_control;

    assign idx = paddr[9:2];
    assign addr_ok = (paddr[dtcu_pkg::ADDR_W-1:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
        (idx == dtcu_pkg::IDX_TIMER_CONTROL || idx == dtcu_pkg::IDX_TIMER_MODE_SELECT ||
         idx == dtcu_pkg::IDX_TIMER_A_LOW_BYTE || idx == dtcu_pkg::IDX_TIMER_B_LOW_BYTE ||
         idx == dtcu_pkg::IDX_TIMER_A_HIGH_BYTE || idx == dtcu_pkg::IDX_TIMER_B_HIGH_BYTE ||
         idx == dtcu_pkg::IDX_IRQ_ENABLE_REG_ZERO);
    // Zero wait states: read data is captured in the setup cycle
    assign pready = psel && penable;
    assign pslverr = psel && penable && st_r.err;
    assign prdata = {24'h0, st_r.rdata};
    assign wr = psel && penable && pwrite && addr_ok;
    assign wr_tl[0] = wr && idx == dtcu_pkg::IDX_TIMER_A_LOW_BYTE;
    assign wr_tl[1] = wr && idx == dtcu_pkg::IDX_TIMER_B_LOW_BYTE;
    assign wr_th[0] = wr && idx == dtcu_pkg::IDX_TIMER_A_HIGH_BYTE;
    assign wr_th[1] = wr && idx == dtcu_pkg::IDX_TIMER_B_HIGH_BYTE;
    assign wr_timer_control = wr && idx == dtcu_pkg::IDX_TIMER_CONTROL;

    ////////////////////////////////////////////////////////////////////////////
    // Count events

    logic tick;
    logic split;
    logic hi_ev;
    logic [1:0] cfall;
    logic [1:0] ifall;
    logic [1:0] run;
    logic [1:0] gate;
    logic [1:0] src;
    logic [1:0][1:0] mode;
    logic [1:0] ev;

    assign tick = (st_r.pre == dtcu_pkg::PRE_LAST);
    assign split = (mode[0] == dtcu_pkg::MODE_SPLIT);
    // High byte of timer a in split mode counts peripheral cycles while the timer b run bit is set
    assign hi_ev = split && tick && st_r.timer_control[dtcu_pkg::TIMER_B_RUN];

    for (genvar i = 0; i < 2; i++) begin : g_src
        assign mode[i] = st_r.timer_mode_select[dtcu_pkg::MODE_NIBBLE*i+dtcu_pkg::MODE_LO +: 2];
        assign src[i] = st_r.timer_mode_select[dtcu_pkg::MODE_NIBBLE*i+dtcu_pkg::SOURCE_SELECT];
        assign gate[i] = st_r.timer_mode_select[dtcu_pkg::MODE_NIBBLE*i+dtcu_pkg::PIN_GATING];
        // Previous sample high and this one low; sampled once per cycle
        assign cfall[i] = tick && st_r.csamp[i] && !st_r.csync2[i];
        assign ifall[i] = st_r.iprev[i] && !st_r.isync2[i];
    end

    // Timer b loses its run bit to the split timer, so it free-runs then
    assign run[0] = st_r.timer_control[dtcu_pkg::TIMER_A_RUN];
    assign run[1] = split || st_r.timer_control[dtcu_pkg::TIMER_B_RUN];
    assign ev[0] = (src[0] ? cfall[0] : tick) && run[0] &&
        (!gate[0] || st_r.isync2[0]);
    assign ev[1] = (src[1] ? cfall[1] : tick) && run[1] && (!gate[1] || st_r.isync2[1]) &&
        (mode[1] != dtcu_pkg::MODE_SPLIT);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [1:0] set_tf;
        logic [1:0] ack_tf;
        logic [1:0] ack_ie;
        logic [15:0] wide;
        set_tf = 2'h0;
        ack_tf = {timer_b_vector_ack, timer_a_vector_ack};
        ack_ie = {ext_irq_b_vector_ack, ext_irq_a_vector_ack};
        wide = 16'h0;
        st_nxt = st_r;
        st_nxt.pre = tick ? 3'h0 : st_r.pre + 3'h1;
        st_nxt.csync1 = {timer_b_count_pin, timer_a_count_pin};
        st_nxt.csync2 = st_r.csync1;
        st_nxt.isync1 = {ext_irq_b_pin, ext_irq_a_pin};
        st_nxt.isync2 = st_r.isync1;
        st_nxt.iprev = st_r.isync2;
        if (tick) begin
            st_nxt.csamp = st_r.csync2;
        end

        for (int i = 0; i < 2; i++) begin
            if (ev[i]) begin
                case (mode[i])
                    dtcu_pkg::MODE_13BIT: begin
                        // Bits 7:5 of the low byte take no part in the count
                        wide = {3'h0, st_r.th[i], st_r.tl[i][4:0]} + 16'h1;
                        st_nxt.tl[i][4:0] = wide[4:0];
                        st_nxt.th[i] = wide[12:5];
                        set_tf[i] = wide[13];
                    end
                    dtcu_pkg::MODE_16BIT: begin
                        wide = {st_r.th[i], st_r.tl[i]} + 16'h1;
                        st_nxt.tl[i] = wide[7:0];
                        st_nxt.th[i] = wide[15:8];
                        set_tf[i] = (st_r.th[i] == 8'hff) && (st_r.tl[i] == 8'hff);
                    end
                    dtcu_pkg::MODE_RELOAD: begin
                        if (st_r.tl[i] == 8'hff) begin
                            // Reads the live high byte, so a late rewrite still applies
                            st_nxt.tl[i] = st_r.th[i];
                            set_tf[i] = 1'b1;
                        end else begin
                            st_nxt.tl[i] = st_r.tl[i] + 8'h1;
                        end
                    end
                    default: begin
                        // Only timer a reaches here; timer b is held by ev
                        st_nxt.tl[i] = st_r.tl[i] + 8'h1;
                        set_tf[i] = (st_r.tl[i] == 8'hff);
                    end
                endcase
            end
        end
        if (hi_ev) begin
            st_nxt.th[0] = st_r.th[0] + 8'h1;
        end
        // Timer b overflows reach no flag while its flag is lent out
        if (split) begin
            set_tf[1] = hi_ev && (st_r.th[0] == 8'hff);
        end

        // Software writes win over counting in the same cycle
        for (int i = 0; i < 2; i++) begin
            if (wr_tl[i]) begin
                st_nxt.tl[i] = pwdata[7:0];
            end
            if (wr_th[i]) begin
                st_nxt.th[i] = pwdata[7:0];
            end
        end
        if (wr && idx == dtcu_pkg::IDX_TIMER_MODE_SELECT) begin
            st_nxt.timer_mode_select = pwdata[7:0];
        end
        if (wr && idx == dtcu_pkg::IDX_IRQ_ENABLE_REG_ZERO) begin
            st_nxt.ien = pwdata[7:0];
        end
        if (wr_timer_control) begin
            st_nxt.timer_control = pwdata[7:0];
        end

        // Hardware set beats a clear arriving in the same cycle
        for (int i = 0; i < 2; i++) begin
            if (ack_tf[i]) begin
                st_nxt.timer_control[dtcu_pkg::TIMER_A_OVERFLOW_FLAG+dtcu_pkg::TIMER_B_STRIDE*i] =
                    1'b0;
            end
            if (set_tf[i]) begin
                st_nxt.timer_control[dtcu_pkg::TIMER_A_OVERFLOW_FLAG+dtcu_pkg::TIMER_B_STRIDE*i] =
                    1'b1;
            end
            if (st_nxt.timer_control[dtcu_pkg::EXT_IRQ_A_EDGE_SELECT+dtcu_pkg::TIMER_B_STRIDE*i]) begin
                if (ack_ie[i]) begin
                    st_nxt.timer_control[dtcu_pkg::EXT_IRQ_A_FLAG+dtcu_pkg::TIMER_B_STRIDE*i] =
                        1'b0;
                end
                if (ifall[i]) begin
                    st_nxt.timer_control[dtcu_pkg::EXT_IRQ_A_FLAG+dtcu_pkg::TIMER_B_STRIDE*i] =
                        1'b1;
                end
            end else begin
                // Level mode: the flag follows the low pin, not the acknowledge
                st_nxt.timer_control[dtcu_pkg::EXT_IRQ_A_FLAG+dtcu_pkg::TIMER_B_STRIDE*i] =
                    !st_r.isync2[i];
            end
        end

        // Read data is taken in the setup cycle and held for the access
        if (psel && !penable) begin
            st_nxt.err = !addr_ok;
            case (idx)
                dtcu_pkg::IDX_TIMER_CONTROL: st_nxt.rdata = st_r.timer_control;
                dtcu_pkg::IDX_TIMER_MODE_SELECT: st_nxt.rdata = st_r.timer_mode_select;
                dtcu_pkg::IDX_TIMER_A_LOW_BYTE: st_nxt.rdata = st_r.tl[0];
                dtcu_pkg::IDX_TIMER_B_LOW_BYTE: st_nxt.rdata = st_r.tl[1];
                dtcu_pkg::IDX_TIMER_A_HIGH_BYTE: st_nxt.rdata = st_r.th[0];
                dtcu_pkg::IDX_TIMER_B_HIGH_BYTE: st_nxt.rdata = st_r.th[1];
                dtcu_pkg::IDX_IRQ_ENABLE_REG_ZERO: st_nxt.rdata = st_r.ien;
                default: st_nxt.rdata = 8'h00;
            endcase
            if (!addr_ok) begin
                st_nxt.rdata = 8'h00;
            end
        end

        if (reset) begin
            st_nxt = '0;
            // Synchronisers restart at the idle high pin level; zeros here would
            // look like a low pin and set the level-mode flags just after reset
            st_nxt.csync1 = '1;
            st_nxt.csync2 = '1;
            st_nxt.csamp = '1;
            st_nxt.isync1 = '1;
            st_nxt.isync2 = '1;
            st_nxt.iprev = '1;
            st_nxt.timer_control = dtcu_pkg::RST_TIMER_CONTROL;
            st_nxt.timer_mode_select = dtcu_pkg::RST_TIMER_MODE_SELECT;
            st_nxt.ien = dtcu_pkg::RST_IRQ_ENABLE;
            for (int i = 0; i < 2; i++) begin
                st_nxt.tl[i] = dtcu_pkg::RST_COUNT_BYTE;
                st_nxt.th[i] = dtcu_pkg::RST_COUNT_BYTE;
            end
        end
    end

    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt requests

    assign timer_a_irq = st_r.timer_control[dtcu_pkg::TIMER_A_OVERFLOW_FLAG] &&
        st_r.ien[dtcu_pkg::TIMER_A_IRQ_ENABLE] && st_r.ien[dtcu_pkg::GLOBAL_IRQ_ENABLE];
    assign timer_b_irq = st_r.timer_control[dtcu_pkg::TIMER_B_OVERFLOW_FLAG] &&
        st_r.ien[dtcu_pkg::TIMER_B_IRQ_ENABLE] && st_r.ien[dtcu_pkg::GLOBAL_IRQ_ENABLE];
    assign ext_irq_a_irq = st_r.timer_control[dtcu_pkg::EXT_IRQ_A_FLAG] &&
        st_r.ien[dtcu_pkg::EXT_IRQ_A_ENABLE] && st_r.ien[dtcu_pkg::GLOBAL_IRQ_ENABLE];
    assign ext_irq_b_irq = st_r.timer_control[dtcu_pkg::EXT_IRQ_A_FLAG+dtcu_pkg::TIMER_B_STRIDE] &&
        st_r.ien[dtcu_pkg::EXT_IRQ_B_ENABLE] && st_r.ien[dtcu_pkg::GLOBAL_IRQ_ENABLE];

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_reload_copy: assert property (
        mode[0] == dtcu_pkg::MODE_RELOAD && ev[0] && st_r.tl[0] == 8'hff &&
        !wr && !timer_a_vector_ack
        |=> st_r.tl[0] == $past(st_r.th[0]) && $stable(st_r.th[0]) &&
            st_r.timer_control[dtcu_pkg::TIMER_A_OVERFLOW_FLAG])
        else $error("reload did not copy high byte or set flag");

    a_tick_period: assert property (
        tick |=> !tick [*5] ##1 tick)
        else $error("peripheral cycle is not six clocks");

    a_halt_hold: assert property (
        mode[1] == dtcu_pkg::MODE_SPLIT && !wr_tl[1] && !wr_th[1]
        |=> $stable(st_r.tl[1]) && $stable(st_r.th[1]))
        else $error("timer b moved in halt mode");

    a_split_high: assert property (
        split && hi_ev && st_r.th[0] == 8'hff && !wr_th[0] && !wr_timer_control
        |=> st_r.th[0] == 8'h00 && st_r.timer_control[dtcu_pkg::TIMER_B_OVERFLOW_FLAG])
        else $error("split high byte overflow missed timer b flag");

    a_gate_block: assert property (
        gate[0] && !st_r.isync2[0] && !wr_tl[0]
        |=> $stable(st_r.tl[0]))
        else $error("timer a counted with gate pin low");

    a_run_stop: assert property (
        !st_r.timer_control[dtcu_pkg::TIMER_A_RUN] && !split && !wr_tl[0] && !wr_th[0]
        |=> $stable(st_r.tl[0]) && $stable(st_r.th[0]))
        else $error("timer a counted while stopped");

    a_flag_ack: assert property (
        timer_a_vector_ack && !ev[0] && !wr_timer_control
        |=> !st_r.timer_control[dtcu_pkg::TIMER_A_OVERFLOW_FLAG])
        else $error("overflow flag survived vector acknowledge");

    a_irq_global: assert property (
        !st_r.ien[dtcu_pkg::GLOBAL_IRQ_ENABLE] |-> !timer_a_irq && !timer_b_irq)
        else $error("timer interrupt without global enable");

    a_reset_zero: assert property (
        $past(reset) |-> st_r.timer_mode_select == 8'h00 && st_r.timer_control == 8'h00 &&
            st_r.tl == 16'h0 && st_r.th == 16'h0)
        else $error("registers not zero after reset");

    a_ext_edge: assert property (
        st_r.timer_control[dtcu_pkg::EXT_IRQ_A_EDGE_SELECT] && ifall[0] && !wr_timer_control
        |=> st_r.timer_control[dtcu_pkg::EXT_IRQ_A_FLAG])
        else $error("falling edge did not set external flag");

    a_mode0_carry: assert property (
        mode[0] == dtcu_pkg::MODE_13BIT && ev[0] && st_r.tl[0][4:0] == 5'h1f &&
        !wr_tl[0] && !wr_th[0]
        |=> st_r.th[0] == $past(st_r.th[0]) + 8'h1 && st_r.tl[0][4:0] == 5'h00)
        else $error("prescaler carry did not reach high byte");

    a_mode1_carry: assert property (
        mode[0] == dtcu_pkg::MODE_16BIT && ev[0] && st_r.tl[0] == 8'hff &&
        !wr_tl[0] && !wr_th[0]
        |=> st_r.th[0] == $past(st_r.th[0]) + 8'h1 && st_r.tl[0] == 8'h00)
        else $error("low byte carry did not reach high byte");

    a_src_hold: assert property (
        src[0] && !cfall[0] && !split && !wr_tl[0] && !wr_th[0]
        |=> $stable(st_r.tl[0]) && $stable(st_r.th[0]))
        else $error("counter moved without a count pin edge");

    a_ext_level: assert property (
        !st_r.timer_control[dtcu_pkg::EXT_IRQ_A_EDGE_SELECT+dtcu_pkg::TIMER_B_STRIDE] && !wr_timer_control
        |=> st_r.timer_control[dtcu_pkg::EXT_IRQ_A_FLAG+dtcu_pkg::TIMER_B_STRIDE] ==
            !$past(st_r.isync2[1]))
        else $error("level-mode external flag does not follow the pin");

    c_reload: cover property (mode[0] == dtcu_pkg::MODE_RELOAD && ev[0] && st_r.tl[0] == 8'hff);
    c_split: cover property (hi_ev && st_r.th[0] == 8'hff);
    c_pin_count: cover property (src[1] && ev[1]);
    c_bus_err: cover property (pslverr);
    c_ext_edge: cover property (ifall[0] && st_r.timer_control[dtcu_pkg::EXT_IRQ_A_EDGE_SELECT]);
endmodule // dtcu_top

// ===== dv/dtcu_pin_model.sv
/*
 * Pin-side model for the dual timer/counter unit: two count pins and two
 * external interrupt pins, idle high, moved only just after a clock edge.
 * Assumes the bench asks for levels or falling pulses through its tasks.
 */
`timescale 1ns/10ps
module dtcu_pin_model (
    input wire logic clk,
    output logic timer_a_count_pin,
    output logic timer_b_count_pin,
    output logic ext_irq_a_pin,
    output logic ext_irq_b_pin
);
    // Index 0 count a, 1 count b, 2 interrupt a, 3 interrupt b
    logic [3:0] lvl_r = 4'hf;
    assign {ext_irq_b_pin, ext_irq_a_pin, timer_b_count_pin, timer_a_count_pin} = lvl_r;

    task automatic set_pin(input int i, input logic v);
        @(posedge clk);
        lvl_r[i] <= v;
    endtask

    // Each level stands 9 clocks, longer than one peripheral cycle, so no sample misses it
    task automatic pulses(input int i, input int n);
        repeat (n) begin
            set_pin(i, 1'b0);
            repeat (8) @(posedge clk);
            set_pin(i, 1'b1);
            repeat (8) @(posedge clk);
        end
    endtask
endmodule // dtcu_pin_model

// ===== dv/tb.sv
/*
 * Self-checking bench for the dual timer/counter unit: a table of timer
 * cases, then reset, halt, gating, counting and interrupt tests.
 * Assumes the zero-wait APB slave and the pin model in this folder.
 */
`timescale 1ns/10ps
module tb;
    typedef struct {
        logic [7:0] timer_mode_select, timer_control, th_a, tl_a, th_b, tl_b, th_late;
        int which, first, period;
    } dtcu_row_s;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [dtcu_pkg::ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, ca, cb, ea, eb;
    logic [3:0] ack = '0;
    logic [3:0] irq;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    dtcu_row_s rows [8];

    always #25 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    dtcu_pin_model dtcu_pin_model_i (.clk(clk), .timer_a_count_pin(ca),
        .timer_b_count_pin(cb), .ext_irq_a_pin(ea), .ext_irq_b_pin(eb));

    dtcu_top dtcu_top_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_a_count_pin(ca), .timer_b_count_pin(cb),
        .ext_irq_a_pin(ea), .ext_irq_b_pin(eb), .timer_a_vector_ack(ack[0]),
        .timer_b_vector_ack(ack[1]), .ext_irq_a_vector_ack(ack[2]),
        .ext_irq_b_vector_ack(ack[3]), .timer_a_irq(irq[0]), .timer_b_irq(irq[1]),
        .ext_irq_a_irq(irq[2]), .ext_irq_b_irq(irq[3]));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_errors++;
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] r;
        logic e;
        apb(1'b0, idx, 8'h00, r, e);
        check(r, exp);
    endtask

    task automatic wait_irq(input int i, input logic lvl, output int t);
        int n = 0;
        while (irq[i] !== lvl && n < 4000) begin
            @(negedge clk);
            n++;
        end
        t = cyc;
    endtask

    task automatic pulse_ack(input int i);
        @(posedge clk);
        ack[i] <= 1'b1;
        @(posedge clk);
        ack[i] <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
    endtask

    task automatic run_row(input dtcu_row_s r);
        int t0, t1, t2;
        do_reset();
        wr(dtcu_pkg::IDX_TIMER_MODE_SELECT, r.timer_mode_select);
        wr(dtcu_pkg::IDX_TIMER_A_HIGH_BYTE, r.th_a);
        wr(dtcu_pkg::IDX_TIMER_A_LOW_BYTE, r.tl_a);
        wr(dtcu_pkg::IDX_TIMER_B_HIGH_BYTE, r.th_b);
        wr(dtcu_pkg::IDX_TIMER_B_LOW_BYTE, r.tl_b);
        wr(dtcu_pkg::IDX_IRQ_ENABLE_REG_ZERO, 8'h8a);
        wr(dtcu_pkg::IDX_TIMER_CONTROL, r.timer_control);
        t0 = cyc;
        if (r.th_late !== 8'h00)
            wr(dtcu_pkg::IDX_TIMER_A_HIGH_BYTE, r.th_late);
        wait_irq(r.which, 1'b1, t1);
        check(t1 - t0 >= r.first - 6 && t1 - t0 <= r.first + 4, 1'b1);
        if (r.period > 0) begin
            pulse_ack(r.which);
            wait_irq(r.which, 1'b0, t2);
            check(t2 - t1 <= 6, 1'b1);
            wait_irq(r.which, 1'b1, t2);
            check(t2 - t1, r.period);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        logic [7:0] r;
        logic e;
        rows = '{
            '{8'h02, 8'h10, 8'hfb, 8'hfb, 8'h00, 8'h00, 8'h00, 0, 30, 30},
            '{8'h02, 8'h10, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 0, 6, 1536},
            '{8'h20, 8'h40, 8'h00, 8'h00, 8'hf0, 8'hf0, 8'h00, 1, 96, 96},
            '{8'h00, 8'h10, 8'hff, 8'hfc, 8'h00, 8'h00, 8'h00, 0, 24, 0},
            '{8'h01, 8'h10, 8'hff, 8'hfd, 8'h00, 8'h00, 8'h00, 0, 18, 0},
            '{8'h03, 8'h10, 8'h00, 8'hfe, 8'h00, 8'h00, 8'h00, 0, 12, 1536},
            '{8'h03, 8'h40, 8'hfc, 8'h00, 8'h00, 8'h00, 8'h00, 1, 24, 1536},
            '{8'h02, 8'h10, 8'h00, 8'hfe, 8'h00, 8'h00, 8'hfb, 0, 12, 30}};
        foreach (rows[k])
            run_row(rows[k]);
        // Reset values, an unmapped index, and mode fields read back
        do_reset();
        rd_chk(dtcu_pkg::IDX_TIMER_CONTROL, dtcu_pkg::RST_TIMER_CONTROL);
        rd_chk(dtcu_pkg::IDX_TIMER_MODE_SELECT, dtcu_pkg::RST_TIMER_MODE_SELECT);
        for (int i = 8'h8a; i <= 8'h8d; i++)
            rd_chk(8'(i), dtcu_pkg::RST_COUNT_BYTE);
        apb(1'b0, 8'h90, 8'h00, r, e);
        check({r, e}, 32'h1);
        wr(dtcu_pkg::IDX_TIMER_MODE_SELECT, 8'ha5);
        rd_chk(dtcu_pkg::IDX_TIMER_MODE_SELECT, 8'ha5);
        // Timer b halted by mode 3 while timer a is split, then released
        do_reset();
        wr(dtcu_pkg::IDX_TIMER_MODE_SELECT, 8'h33);
        wr(dtcu_pkg::IDX_TIMER_B_LOW_BYTE, 8'h55);
        wr(dtcu_pkg::IDX_TIMER_CONTROL, 8'h40);
        repeat (60) @(posedge clk);
        rd_chk(dtcu_pkg::IDX_TIMER_B_LOW_BYTE, 8'h55);
        wr(dtcu_pkg::IDX_TIMER_MODE_SELECT, 8'h03);
        repeat (60) @(posedge clk);
        apb(1'b0, dtcu_pkg::IDX_TIMER_B_LOW_BYTE, 8'h00, r, e);
        check(r !== 8'h55, 1'b1);
        // Gated counter on pin a: edges ignored while the gate pin is low
        do_reset();
        dtcu_pin_model_i.set_pin(2, 1'b0);
        wr(dtcu_pkg::IDX_TIMER_MODE_SELECT, 8'h0d);
        wr(dtcu_pkg::IDX_TIMER_CONTROL, 8'h10);
        dtcu_pin_model_i.pulses(0, 3);
        rd_chk(dtcu_pkg::IDX_TIMER_A_LOW_BYTE, 8'h00);
        dtcu_pin_model_i.set_pin(2, 1'b1);
        repeat (8) @(posedge clk);
        dtcu_pin_model_i.pulses(0, 5);
        rd_chk(dtcu_pkg::IDX_TIMER_A_LOW_BYTE, 8'h05);
        // External interrupts: b level mode, a edge mode with acknowledge
        do_reset();
        wr(dtcu_pkg::IDX_IRQ_ENABLE_REG_ZERO, 8'h85);
        wr(dtcu_pkg::IDX_TIMER_CONTROL, 8'h01);
        dtcu_pin_model_i.set_pin(3, 1'b0);
        repeat (4) @(negedge clk);
        check(irq[3], 1'b1);
        dtcu_pin_model_i.set_pin(3, 1'b1);
        repeat (4) @(negedge clk);
        check(irq[3], 1'b0);
        dtcu_pin_model_i.pulses(2, 1);
        rd_chk(dtcu_pkg::IDX_TIMER_CONTROL, 8'h03);
        @(negedge clk);
        check(irq[2], 1'b1);
        pulse_ack(2);
        repeat (2) @(negedge clk);
        check(irq[2], 1'b0);
        // Timer a flag set but held back until the global enable is on
        wr(dtcu_pkg::IDX_TIMER_MODE_SELECT, 8'h02);
        wr(dtcu_pkg::IDX_TIMER_A_HIGH_BYTE, 8'hfb);
        wr(dtcu_pkg::IDX_TIMER_A_LOW_BYTE, 8'hfb);
        wr(dtcu_pkg::IDX_IRQ_ENABLE_REG_ZERO, 8'h02);
        wr(dtcu_pkg::IDX_TIMER_CONTROL, 8'h11);
        repeat (300) @(negedge clk);
        rd_chk(dtcu_pkg::IDX_TIMER_CONTROL, 8'h31);
        check(irq[0], 1'b0);
        wr(dtcu_pkg::IDX_IRQ_ENABLE_REG_ZERO, 8'h82);
        @(negedge clk);
        check(irq[0], 1'b1);
        tally_and_finish();
    end
endmodule // tb
